// >>> src/otp_image_mem.sv
// Image memory: 32K bytes holding the program image in device addressing.
// Assumes a single clock; read data appears one cycle after the address.
`timescale 1ns/1ns
`default_nettype none
module otp_image_mem (
   // Clock
   input wire logic clk_i,
   // Write port
   input wire logic wr_en_i,
   input wire logic [14:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   // Read port
   input wire logic [14:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem [0:32767];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end
endmodule
`default_nettype wire

// >>> src/otp_prog_pkg.sv
// Constants and carrier types for the OTP programmer controller.
// Assumes a 20 MHz system clock driving all programmer timing.
package otp_prog_pkg;
   localparam int unsigned clk_mhz = 20;
   localparam int unsigned pulse1_us = 1000;
   localparam int unsigned pulse2_us = 100;
   localparam int unsigned pulse1_cycles = pulse1_us * clk_mhz;
   localparam int unsigned pulse2_cycles = pulse2_us * clk_mhz;
   localparam int unsigned settle_cycles = 4;
   localparam int unsigned max_tries = 25;
   localparam int unsigned over_factor = 3;
   localparam logic [14:0] base_16k = 15'h4000;
   localparam logic [14:0] base_32k = 15'h0000;
   localparam logic [14:0] last_addr = 15'h7fff;
   localparam logic [7:0] blank_byte = 8'hff;
   localparam logic [15:0] mcu_base_16k = 16'hc000;
   localparam logic [15:0] mcu_base_32k = 16'h8000;

   typedef struct packed {
      logic [14:0] addr;
      logic [7:0] data;
   } word_s;

   typedef struct packed {
      logic test_vpp;
      logic reset_n;
      logic set_high;
      logic set_low;
   } mode_pins_s;

   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_setup = 4'b0001,
      st_fetch = 4'b0011,
      st_pulse = 4'b0010,
      st_read = 4'b0110,
      st_check = 4'b0111,
      st_over = 4'b0101,
      st_next = 4'b0100,
      st_vfy_read = 4'b1100,
      st_vfy_check = 4'b1101,
      st_done = 4'b1111,
      st_fail = 4'b1110
   } state_e;
endpackage

// >>> src/otp_programmer.sv
// Programmer controller that drives an OTP microcontroller in program mode.
// Assumes the device pins are wired through an adapter; data pins are
// bidirectional and resolved outside from the output enable.
// Function
// (R1) Device runs as MCU while the test pin is low; never float it.
// (R2) 16K image C000-FFFF goes to program-mode addresses 4000-7FFF.
// (R3) 32K image 8000-FFFF maps to program-mode addresses 0000-7FFF.
// (R4) For 16K, addresses 0000-3FFF get FF or are skipped.
// (R5) Algorithm I: one 1 ms low chip-enable pulse after stable inputs.
// (R6) Read back after each pulse; retry up to 25 pulses per address.
// (R7) Algorithm I: extra pulse of three times pulses used times 1 ms.
// (R8) Algorithm II: 0.1 ms pulses, same retry, no extra pulse.
// (R9) After programming, read and compare every address once more.
// (R10) Chip enable is active low; selects array and strobes programming.
// (R11) Output enable is active low; device drives data only then.
// (R12) Never apply identification voltage to address line nine.
// (R13) Hold mode-setting pins: one group high, another group low.
// (R14) Program mode needs test, reset and setting pins together.
// (R15) Keep an 8 MHz oscillator running on the device clock pins.
// (R16) 15-bit address and 8-bit bidirectional data bus.
`timescale 1ns/1ns
`default_nettype none
module otp_programmer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Image load port, MCU addressing
   input wire logic load_en_i,
   input wire logic [15:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   // Command and status
   input wire logic start_i,
   input wire logic size_32k_i,
   input wire logic algo_two_i,
   output logic busy_o,
   output logic done_o,
   output logic fail_o,
   output logic [14:0] fail_addr_o,
   // Device mode pins
   output otp_prog_pkg::mode_pins_s mode_pins_o,
   output logic osc_en_o,
   // Device program port
   output logic [14:0] program_mode_addr_lines_o,
   output logic ce_n_o,
   output logic oe_n_o,
   input wire logic [7:0] program_mode_data_lines_i,
   output logic [7:0] program_mode_data_lines_o,
   output logic program_mode_data_oe_o
);
   // -----------------------------------------------------------------
   // Input synchronisers for the device data pins
   // -----------------------------------------------------------------
   logic [7:0] data_meta;
   logic [7:0] data_sync;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_meta <= 8'h00;
         data_sync <= 8'h00;
      end else begin
         data_meta <= program_mode_data_lines_i;
         data_sync <= data_meta;
      end
   end

   // -----------------------------------------------------------------
   // Image storage
   // -----------------------------------------------------------------
   logic [14:0] wr_addr;
   logic [7:0] img_byte;
   logic [14:0] addr;
   logic [14:0] next_addr;

   // Image words are stored at their program-mode address
   always_comb begin
      if (size_32k_i) begin
         wr_addr = load_addr_i[14:0]; // [R3]
      end else begin
         wr_addr = {1'b1, load_addr_i[13:0]}; // [R2]
      end
   end

   otp_image_mem u_mem (
      .clk_i(clk_i),
      .wr_en_i(load_en_i & ~busy_o),
      .wr_addr_i(wr_addr),
      .wr_data_i(load_data_i),
      .rd_addr_i(next_addr), // Lookahead keeps img_byte aligned to addr
      .rd_data_o(img_byte)
   );

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   otp_prog_pkg::state_e state;
   otp_prog_pkg::state_e next_state;
   logic [21:0] timer;
   logic [21:0] next_timer;
   logic [4:0] tries;
   logic [4:0] next_tries;
   logic [7:0] wdata;
   logic [7:0] next_wdata;
   logic algo2;
   logic next_algo2;
   logic big;
   logic next_big;
   logic [14:0] bad;
   logic [14:0] next_bad;
   logic [14:0] first_addr;
   logic [21:0] unit_cycles;
   logic [21:0] over_cycles;

   // 16K parts are programmed only inside their window
   assign first_addr = big ? otp_prog_pkg::base_32k
                           : otp_prog_pkg::base_16k; // [R4]
   assign unit_cycles = algo2 ? 22'(otp_prog_pkg::pulse2_cycles)
                              : 22'(otp_prog_pkg::pulse1_cycles);
   // Extra pulse length: 3 x pulses used x 1 ms
   assign over_cycles = 22'(otp_prog_pkg::over_factor * tries *
                            otp_prog_pkg::pulse1_cycles); // [R7]

   always_comb begin
      next_state = state;
      next_addr = addr;
      next_timer = timer;
      next_tries = tries;
      next_wdata = wdata;
      next_algo2 = algo2;
      next_big = big;
      next_bad = bad;
      case (state)
         otp_prog_pkg::st_idle,
         otp_prog_pkg::st_done,
         otp_prog_pkg::st_fail: begin
            if (start_i) begin
               next_algo2 = algo_two_i;
               next_big = size_32k_i;
               next_addr = size_32k_i ? otp_prog_pkg::base_32k
                                      : otp_prog_pkg::base_16k;
               next_timer = 22'(otp_prog_pkg::settle_cycles);
               next_state = otp_prog_pkg::st_setup;
            end
         end
         // Mode pins settle before the first access
         otp_prog_pkg::st_setup: begin
            if (timer == 22'h0) begin
               next_state = otp_prog_pkg::st_fetch; // [R14]
            end else begin
               next_timer = timer - 22'h1;
            end
         end
         otp_prog_pkg::st_fetch: begin
            next_wdata = img_byte;
            next_tries = 5'h0;
            next_timer = unit_cycles;
            next_state = otp_prog_pkg::st_pulse;
         end
         otp_prog_pkg::st_pulse: begin
            if (timer == 22'h0) begin
               next_tries = tries + 5'h1;
               next_timer = 22'(otp_prog_pkg::settle_cycles);
               next_state = otp_prog_pkg::st_read;
            end else begin
               next_timer = timer - 22'h1;
            end
         end
         otp_prog_pkg::st_read: begin
            if (timer == 22'h0) begin
               next_state = otp_prog_pkg::st_check;
            end else begin
               next_timer = timer - 22'h1;
            end
         end
         otp_prog_pkg::st_check: begin
            if (data_sync == wdata) begin
               if (algo2) begin
                  next_state = otp_prog_pkg::st_next; // [R8]
               end else begin
                  next_timer = over_cycles;
                  next_state = otp_prog_pkg::st_over; // [R7]
               end
            end else if (tries == 5'(otp_prog_pkg::max_tries)) begin
               next_bad = addr;
               next_state = otp_prog_pkg::st_fail; // [R6]
            end else begin
               next_timer = unit_cycles;
               next_state = otp_prog_pkg::st_pulse; // [R6]
            end
         end
         otp_prog_pkg::st_over: begin
            if (timer == 22'h0) begin
               next_state = otp_prog_pkg::st_next;
            end else begin
               next_timer = timer - 22'h1;
            end
         end
         otp_prog_pkg::st_next: begin
            if (addr == otp_prog_pkg::last_addr) begin
               next_addr = first_addr;
               next_timer = 22'(otp_prog_pkg::settle_cycles);
               next_state = otp_prog_pkg::st_vfy_read; // [R9]
            end else begin
               next_addr = addr + 15'h1;
               next_state = otp_prog_pkg::st_fetch;
            end
         end
         // Final pass: pin and synchroniser latency is covered by the settle wait
         otp_prog_pkg::st_vfy_read: begin
            if (timer == 22'h0) begin
               next_state = otp_prog_pkg::st_vfy_check;
            end else begin
               next_timer = timer - 22'h1;
            end
         end
         otp_prog_pkg::st_vfy_check: begin
            if (data_sync != img_byte) begin
               next_bad = addr;
               next_state = otp_prog_pkg::st_fail; // [R9]
            end else if (addr == otp_prog_pkg::last_addr) begin
               next_state = otp_prog_pkg::st_done;
            end else begin
               next_addr = addr + 15'h1;
               next_timer = 22'(otp_prog_pkg::settle_cycles);
               next_state = otp_prog_pkg::st_vfy_read;
            end
         end
         default: begin
            next_state = otp_prog_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= otp_prog_pkg::st_idle;
         addr <= 15'h0;
         timer <= 22'h0;
         tries <= 5'h0;
         wdata <= 8'h00;
         algo2 <= 1'b0;
         big <= 1'b0;
         bad <= 15'h0;
      end else begin
         state <= next_state;
         addr <= next_addr;
         timer <= next_timer;
         tries <= next_tries;
         wdata <= next_wdata;
         algo2 <= next_algo2;
         big <= next_big;
         bad <= next_bad;
      end
   end

   // -----------------------------------------------------------------
   // Registered pin drive
   // -----------------------------------------------------------------
   logic active;
   logic reading;
   otp_prog_pkg::mode_pins_s next_pins;

   assign active = (next_state != otp_prog_pkg::st_idle) &&
                   (next_state != otp_prog_pkg::st_done) &&
                   (next_state != otp_prog_pkg::st_fail);
   assign reading = (next_state == otp_prog_pkg::st_read) ||
                    (next_state == otp_prog_pkg::st_check) ||
                    (next_state == otp_prog_pkg::st_vfy_read) ||
                    (next_state == otp_prog_pkg::st_vfy_check);

   // Test pin is always driven, low outside a run, so it never floats
   always_comb begin
      next_pins.test_vpp = active; // [R1]
      next_pins.reset_n = ~active; // [R14]
      next_pins.set_high = 1'b1; // [R13]
      next_pins.set_low = 1'b0; // [R13]
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_pins_o <= '{test_vpp: 1'b0, reset_n: 1'b1,
                          set_high: 1'b1, set_low: 1'b0};
         osc_en_o <= 1'b0;
         program_mode_addr_lines_o <= 15'h0;
         ce_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         program_mode_data_lines_o <= 8'h00;
         program_mode_data_oe_o <= 1'b0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         fail_o <= 1'b0;
         fail_addr_o <= 15'h0;
      end else begin
         mode_pins_o <= next_pins;
         osc_en_o <= active; // [R15]
         // Address is plain logic level; line nine never sees high voltage
         program_mode_addr_lines_o <= next_addr; // [R16] [R12]
         ce_n_o <= ~((next_state == otp_prog_pkg::st_pulse) ||
                     (next_state == otp_prog_pkg::st_over) ||
                     reading); // [R10] [R5]
         oe_n_o <= ~reading; // [R11]
         program_mode_data_lines_o <= next_wdata;
         // Stop driving on the same edge that lets the device drive during read
         program_mode_data_oe_o <= active && !reading; // [R11] [R16]
         busy_o <= active;
         done_o <= (next_state == otp_prog_pkg::st_done);
         fail_o <= (next_state == otp_prog_pkg::st_fail);
         fail_addr_o <= next_bad;
      end
   end
endmodule
`default_nettype wire

// >>> verification/otp_device_model.sv
// Behavioural OTP part in program mode, blank cells read as ones.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/1ns
`default_nettype none
module otp_device_model (
   // Clock
   input wire logic clk_i,
   // Mode and program port
   input wire otp_prog_pkg::mode_pins_s mode_i,
   input wire logic osc_i,
   input wire logic [14:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic [7:0] data_i,
   input wire logic stuck_i,
   output logic [7:0] data_o,
   output logic data_oe_o
);
   logic [7:0] cells [0:32767];
   logic prog;
   // Test pin low keeps the part in MCU mode, deaf to the port
   assign prog = mode_i.test_vpp && !mode_i.reset_n && mode_i.set_high
      && !mode_i.set_low && osc_i;
   initial begin
      for (int i = 0; i < 32768; i++) begin
         cells[i] = 8'hff;
      end
   end
   // Cells only lose ones; stuck models a byte that never takes
   always @(posedge clk_i) begin
      if (prog && !ce_n_i && oe_n_i && !stuck_i) begin
         cells[addr_i] <= cells[addr_i] & data_i;
      end
   end
   assign data_oe_o = prog && !ce_n_i && !oe_n_i;
   assign data_o = cells[addr_i];
endmodule
`default_nettype wire

// >>> verification/otp_programmer_sva.sv
// Checker on the programmer's port timing.
// Assumes one clock domain; bound into every programmer instance.
`timescale 1ns/1ns
`default_nettype none
module otp_programmer_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Command and status
   input wire logic start_i,
   input wire logic size_32k_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic fail_o,
   // Device pins
   input wire otp_prog_pkg::mode_pins_s mode_pins_o,
   input wire logic osc_en_o,
   input wire logic [14:0] program_mode_addr_lines_o,
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic [7:0] program_mode_data_lines_o,
   input wire logic program_mode_data_oe_o
);
   logic pulse;
   int plen;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   assign pulse = !ce_n_o && oe_n_o && program_mode_data_oe_o;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         plen <= 0;
      end else begin
         plen <= pulse ? plen + 1 : 0;
      end
   end
   mode_pins_a: assert property (
      busy_o && $past(busy_o) |-> mode_pins_o.test_vpp && !mode_pins_o.reset_n)
      else $error("mode pins wrong during run");
   set_pins_a: assert property (
      mode_pins_o.set_high && !mode_pins_o.set_low)
      else $error("setting pins wrong");
   mcu_idle_a: assert property (
      !busy_o && !$past(busy_o) |-> !mode_pins_o.test_vpp)
      else $error("program voltage while idle");
   osc_run_a: assert property (busy_o && $past(busy_o) |-> osc_en_o)
      else $error("oscillator off during run");
   read_bus_a: assert property (
      !oe_n_o |-> !program_mode_data_oe_o && !ce_n_o)
      else $error("bus driven during read");
   pulse_hold_a: assert property (
      pulse && $past(pulse) |-> $stable(program_mode_addr_lines_o)
      && $stable(program_mode_data_lines_o))
      else $error("address or data moved in pulse");
   pulse_len_a: assert property (
      $fell(pulse) |-> plen >= otp_prog_pkg::pulse2_cycles + 1)
      else $error("program pulse too short");
   low_area_a: assert property (
      busy_o && !size_32k_i && !ce_n_o
      |-> program_mode_addr_lines_o >= otp_prog_pkg::base_16k)
      else $error("access below small part window");
   start_run_a: assert property (start_i && !busy_o |=> busy_o)
      else $error("start not taken");
   run_end_a: assert property (
      $rose(done_o) || $rose(fail_o) |-> !busy_o && $past(busy_o))
      else $error("run end without busy drop");
endmodule
bind otp_programmer otp_programmer_chk u_chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
   .size_32k_i(size_32k_i), .busy_o(busy_o), .done_o(done_o),
   .fail_o(fail_o), .mode_pins_o(mode_pins_o), .osc_en_o(osc_en_o),
   .program_mode_addr_lines_o(program_mode_addr_lines_o), .ce_n_o(ce_n_o),
   .oe_n_o(oe_n_o), .program_mode_data_lines_o(program_mode_data_lines_o),
   .program_mode_data_oe_o(program_mode_data_oe_o)
);
`default_nettype wire

// >>> verification/otp_programmer_tb_top.sv
// Bench for the OTP programmer against a behavioural part.
// Assumes a 20 MHz clock; runs are cut short, full passes are too long.
`timescale 1ns/1ns
`default_nettype none
module otp_programmer_tb_top;
   typedef struct {otp_prog_pkg::word_s w; int len;} note_s;
   logic clk_i = 0, rstn_i = 0, load_en_i = 0, start_i = 0;
   logic size_32k_i = 0, algo_two_i = 0, stuck = 0;
   logic [15:0] load_addr_i = 16'h0000;
   logic [7:0] load_data_i = 8'h00, float_pat = 8'h00, d0, d1;
   logic busy_o, done_o, fail_o, osc_en_o, ce_n_o, oe_n_o, program_mode_data_oe_o;
   logic dev_oe;
   logic [14:0] fail_addr_o, program_mode_addr_lines_o;
   logic [7:0] program_mode_data_lines_o, dev_data;
   wire logic [7:0] program_mode_data_lines_i;
   otp_prog_pkg::mode_pins_s mode_pins_o;
   otp_prog_pkg::word_s seen;
   note_s notes[$];
   note_s e;
   int n_fail = 0, compares = 0, plen = 0, cycles = 0, seed = 32'hd76f;
   // ------------------------------------------------------------
   // Wiring
   // ------------------------------------------------------------
   // Released lines carry a moving pattern, never a stale byte
   assign program_mode_data_lines_i = program_mode_data_oe_o ? program_mode_data_lines_o :
      dev_oe ? dev_data : float_pat;
   otp_programmer DUT (.clk_i(clk_i), .rstn_i(rstn_i),
      .load_en_i(load_en_i), .load_addr_i(load_addr_i),
      .load_data_i(load_data_i), .start_i(start_i),
      .size_32k_i(size_32k_i), .algo_two_i(algo_two_i), .busy_o(busy_o),
      .done_o(done_o), .fail_o(fail_o), .fail_addr_o(fail_addr_o),
      .mode_pins_o(mode_pins_o), .osc_en_o(osc_en_o),
      .program_mode_addr_lines_o(program_mode_addr_lines_o), .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o), .program_mode_data_lines_i(program_mode_data_lines_i),
      .program_mode_data_lines_o(program_mode_data_lines_o),
      .program_mode_data_oe_o(program_mode_data_oe_o));
   otp_device_model part (.clk_i(clk_i), .mode_i(mode_pins_o),
      .osc_i(osc_en_o), .addr_i(program_mode_addr_lines_o), .ce_n_i(ce_n_o),
      .oe_n_i(oe_n_o), .data_i(program_mode_data_lines_i), .stuck_i(stuck),
      .data_o(dev_data), .data_oe_o(dev_oe));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      float_pat <= float_pat + 8'h35;
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         n_fail++;
         tally_and_finish;
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #5;
   endtask
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic load(input logic [15:0] a, input logic [7:0] d);
      load_en_i = 1;
      load_addr_i = a;
      load_data_i = d;
      tick(1);
      load_en_i = 0;
      // Let an edge pass so a following load never re-raises in one step
      tick(1);
   endtask
   task automatic run(input logic sz, input logic alg);
      size_32k_i = sz;
      algo_two_i = alg;
      start_i = 1;
      tick(1);
      start_i = 0;
   endtask
   task automatic expect_pulse(input logic [14:0] a, input logic [7:0] d,
      input int len, input int times);
      for (int i = 0; i < times; i++) begin
         notes.push_back('{'{a, d}, len});
      end
   endtask
   task automatic drain(input int limit);
      for (int k = 0; k < limit && notes.size() != 0; k++) begin
         tick(1);
      end
   endtask
   task automatic do_reset;
      rstn_i = 0;
      tick(3);
      rstn_i = 1;
   endtask
   task automatic tally_and_finish;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Pulse watcher
   // ------------------------------------------------------------
   always @(negedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         plen = 0;
      end else if (ce_n_o === 1'b0 && oe_n_o === 1'b1) begin
         if (plen == 0) begin
            seen = '{program_mode_addr_lines_o, program_mode_data_lines_o};
         end
         plen++;
      end else if (plen != 0) begin
         compares++;
         if (notes.size() != 0) begin
            e = notes.pop_front();
         end else begin
            e = '{'{15'h0, 8'h0}, 0};
         end
         if (seen !== e.w || plen != e.len) begin
            n_fail++;
            $display("mismatch at %0t: pulse %h len %0d", $time, seen, plen);
         end
         plen = 0;
      end
   end
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      tick(3);
      rstn_i = 1;
      chk(ce_n_o === 1'b1 && oe_n_o === 1'b1 && program_mode_data_oe_o === 1'b0
         && mode_pins_o.test_vpp === 1'b0, "reset levels");
      // Byte that never takes: exactly 25 short pulses, then fail
      d0 = 8'($random(seed)) & 8'h7f;
      stuck = 1;
      load(16'hc000, d0);
      expect_pulse(15'h4000, d0, otp_prog_pkg::pulse2_cycles + 1, 25);
      run(1'b0, 1'b1);
      for (int k = 0; k < 60000 && fail_o !== 1'b1; k++) begin
         tick(1);
      end
      tick(4);
      chk(fail_o === 1'b1 && busy_o === 1'b0 && done_o === 1'b0,
         "no fail");
      chk(fail_addr_o === 15'h4000 && notes.size() == 0, "fail addr");
      $display("test retry_limit done");
      // Small part, algorithm II, load refused while busy
      do_reset;
      stuck = 0;
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      load(16'hc000, d0);
      load(16'hc001, d1);
      expect_pulse(15'h4000, d0, otp_prog_pkg::pulse2_cycles + 1, 1);
      expect_pulse(15'h4001, d1, otp_prog_pkg::pulse2_cycles + 1, 1);
      run(1'b0, 1'b1);
      load(16'hc001, ~d1);
      drain(6000);
      chk(notes.size() == 0 && mode_pins_o.reset_n === 1'b0
         && osc_en_o === 1'b1, "small part run");
      $display("test small_alg2 done");
      // Large part, algorithm I, extra pulse on the same address
      do_reset;
      size_32k_i = 1;
      d0 = 8'($random(seed)) & 8'hfe;
      load(16'h8000, d0);
      expect_pulse(15'h0000, d0, otp_prog_pkg::pulse1_cycles + 1, 1);
      run(1'b1, 1'b0);
      drain(22000);
      for (int k = 0; k < 40 && !(ce_n_o === 1'b0 && oe_n_o === 1'b1);
         k++) begin
         tick(1);
      end
      chk(ce_n_o === 1'b0 && program_mode_addr_lines_o === 15'h0000
         && notes.size() == 0, "extra pulse");
      // Still low well past one unit pulse: the extra pulse is the long one
      tick(20050);
      chk(ce_n_o === 1'b0 && oe_n_o === 1'b1 && notes.size() == 0,
         "extra pulse too short");
      tick(8);
      do_reset;
      $display("test large_alg1 done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
